/* File: rtl/atc_timer.sv */
// 8-bit timer/counter with one compare channel, four waveform modes, a
// prescaler and asynchronous register update through temporary registers.
// Assumes all inputs except the oscillator input, which is synchronised here, are synchronous to ref_clk
// and that the oscillator runs well below a quarter of the ref_clk rate.
//
// The plain strobed port and the address map were left to the implementer.
`timescale 1ns/100ps
`include "atc_defs.svh"

module atc_timer (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic clkEn,
  input wire logic [`ATC_ADDR_W-1:0] regAddr,
  input wire atc_pkg::atc_byte_t regWrData,
  input wire logic regWr,
  input wire logic regRd,
  output atc_pkg::atc_byte_t regRdData,
  input wire logic timerOscIn,
  input wire logic portDirBit,
  input wire logic cmpVectorTaken,
  input wire logic ovfVectorTaken,
  output logic compareOutPin,
  output logic compareOutEn,
  output logic compareFlag,
  output logic overflowFlag
);
  import atc_pkg::*;

  // Divided tick for a clock select code; prescaler taps are free-running bits.
  function automatic logic divTick(input logic [2:0] sel, input logic [`ATC_PRE_W-1:0] pre,
                                   input logic src);
    logic tap;
    tap = 1'b0;
    unique case (sel)
      3'h0: tap = 1'b0;
      3'h1: tap = 1'b1;
      3'h2: tap = &pre[2:0];
      3'h3: tap = &pre[4:0];
      3'h4: tap = &pre[5:0];
      3'h5: tap = &pre[6:0];
      3'h6: tap = &pre[7:0];
      3'h7: tap = &pre[9:0];
    endcase
    return src & tap;
  endfunction : divTick

  // Oscillator input synchroniser and edge detector.
  logic oscMeta, oscSync, oscLast;
  logic next_oscMeta, next_oscSync, next_oscLast;
  logic oscRise;

  always_comb begin
    next_oscMeta = timerOscIn;
    next_oscSync = oscMeta;
    next_oscLast = oscSync;
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      oscMeta <= 1'b0;
      oscSync <= 1'b0;
      oscLast <= 1'b0;
    end else if (clkEn) begin
      oscMeta <= next_oscMeta;
      oscSync <= next_oscSync;
      oscLast <= next_oscLast;
    end
  end

  assign oscRise = oscSync & ~oscLast;

  // Register write side: temporaries, busy flags and commit edge counters.
  logic asyncSel, next_asyncSel;
  logic [6:0] ctrlReg, next_ctrlReg, ctlTemp, next_ctlTemp;
  logic focTemp, next_focTemp, focPend, next_focPend;
  atc_byte_t ocrReg, next_ocrReg, ocrTemp, next_ocrTemp;
  atc_byte_t cntTemp, next_cntTemp;
  logic ctlBusy, ocrBusy, cntBusy, next_ctlBusy, next_ocrBusy, next_cntBusy;
  logic [1:0] ctlEdges, ocrEdges, cntEdges, next_ctlEdges, next_ocrEdges, next_cntEdges;
  logic psrPend, next_psrPend;
  logic cntLoad, next_cntLoad;
  atc_byte_t cntLoadVal, next_cntLoadVal;
  logic wrCtl, wrOcr, wrCnt;
  logic ctlCommit, ocrCommit, cntCommit;

  assign wrCtl = regWr && (regAddr == `ATC_OFF_CTRL);
  assign wrOcr = regWr && (regAddr == `ATC_OFF_COMPARE);
  assign wrCnt = regWr && (regAddr == `ATC_OFF_COUNT);
  // The second oscillator edge after the write commits the temporary.
  assign ctlCommit = ctlBusy && oscRise && (ctlEdges == `ATC_COMMIT_EDGES - 2'h1);
  assign ocrCommit = ocrBusy && oscRise && (ocrEdges == `ATC_COMMIT_EDGES - 2'h1);
  assign cntCommit = cntBusy && oscRise && (cntEdges == `ATC_COMMIT_EDGES - 2'h1);

  always_comb begin
    next_asyncSel = asyncSel;
    next_ctrlReg = ctrlReg;
    next_ctlTemp = ctlTemp;
    next_focTemp = focTemp;
    next_focPend = 1'b0;
    next_ocrReg = ocrReg;
    next_ocrTemp = ocrTemp;
    next_cntTemp = cntTemp;
    next_ctlBusy = ctlBusy;
    next_ocrBusy = ocrBusy;
    next_cntBusy = cntBusy;
    next_ctlEdges = ctlEdges;
    next_ocrEdges = ocrEdges;
    next_cntEdges = cntEdges;
    next_psrPend = psrPend;
    next_cntLoad = 1'b0;
    next_cntLoadVal = cntLoadVal;
    // Each temporary moves on its own; one in flight never disturbs another.
    if (ctlBusy && oscRise) next_ctlEdges = ctlEdges + 2'h1;
    if (ocrBusy && oscRise) next_ocrEdges = ocrEdges + 2'h1;
    if (cntBusy && oscRise) next_cntEdges = cntEdges + 2'h1;
    if (ctlCommit) begin
      next_ctrlReg = ctlTemp;
      next_focPend = focTemp;
      next_ctlBusy = 1'b0;
    end
    if (ocrCommit) begin
      next_ocrReg = ocrTemp;
      next_ocrBusy = 1'b0;
    end
    if (cntCommit) begin
      next_cntLoad = 1'b1;
      next_cntLoadVal = cntTemp;
      next_cntBusy = 1'b0;
    end
    // Writing the async select bit does not fix up the timer registers.
    if (regWr && (regAddr == `ATC_OFF_STATUS)) next_asyncSel = regWrData[`ATC_STAT_ASYNC];
    if (wrCtl) begin
      next_ctlTemp = regWrData[6:0];
      next_focTemp = regWrData[`ATC_CTRL_FORCE];
      if (asyncSel) begin
        next_ctlBusy = 1'b1;
        next_ctlEdges = 2'h0;
      end else begin
        next_ctrlReg = regWrData[6:0];
        next_focPend = regWrData[`ATC_CTRL_FORCE];
      end
    end
    if (wrOcr) begin
      next_ocrTemp = regWrData;
      if (asyncSel) begin
        next_ocrBusy = 1'b1;
        next_ocrEdges = 2'h0;
      end else begin
        next_ocrReg = regWrData;
      end
    end
    if (wrCnt) begin
      next_cntTemp = regWrData;
      if (asyncSel) begin
        next_cntBusy = 1'b1;
        next_cntEdges = 2'h0;
      end else begin
        next_cntLoad = 1'b1;
        next_cntLoadVal = regWrData;
      end
    end
    // In synchronous mode the prescaler resets on the next cycle; in async mode
    // it waits for an oscillator edge, so the bit stays visible meanwhile.
    if (psrPend && (!asyncSel || oscRise)) next_psrPend = 1'b0;
    if (regWr && (regAddr == `ATC_OFF_PRESCALE) && regWrData[`ATC_PRESCALE_RST]) begin
      next_psrPend = 1'b1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      asyncSel <= 1'b0;
      ctrlReg <= `ATC_CTRL_RESET;
      ctlTemp <= `ATC_CTRL_RESET;
      focTemp <= 1'b0;
      focPend <= 1'b0;
      ocrReg <= 8'h00;
      ocrTemp <= 8'h00;
      cntTemp <= 8'h00;
      ctlBusy <= 1'b0;
      ocrBusy <= 1'b0;
      cntBusy <= 1'b0;
      ctlEdges <= 2'h0;
      ocrEdges <= 2'h0;
      cntEdges <= 2'h0;
      psrPend <= 1'b0;
      cntLoad <= 1'b0;
      cntLoadVal <= 8'h00;
    end else if (clkEn) begin
      asyncSel <= next_asyncSel;
      ctrlReg <= next_ctrlReg;
      ctlTemp <= next_ctlTemp;
      focTemp <= next_focTemp;
      focPend <= next_focPend;
      ocrReg <= next_ocrReg;
      ocrTemp <= next_ocrTemp;
      cntTemp <= next_cntTemp;
      ctlBusy <= next_ctlBusy;
      ocrBusy <= next_ocrBusy;
      cntBusy <= next_cntBusy;
      ctlEdges <= next_ctlEdges;
      ocrEdges <= next_ocrEdges;
      cntEdges <= next_cntEdges;
      psrPend <= next_psrPend;
      cntLoad <= next_cntLoad;
      cntLoadVal <= next_cntLoadVal;
    end
  end

  // Prescaler on the timer source clock.
  logic [`ATC_PRE_W-1:0] preCnt, next_preCnt;
  logic srcTick, tick;

  assign srcTick = asyncSel ? oscRise : 1'b1;

  always_comb begin
    next_preCnt = preCnt;
    if (psrPend && (!asyncSel || oscRise)) begin
      next_preCnt = '0;
    end else if (srcTick) begin
      next_preCnt = preCnt + `ATC_PRE_W'(1);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      preCnt <= '0;
    end else if (clkEn) begin
      preCnt <= next_preCnt;
    end
  end

  assign tick = divTick(ctrlReg[2:0], preCnt, srcTick);

  // Counter, compare and waveform engine.
  atc_byte_t cnt, next_cnt, ocrAct, next_ocrAct;
  logic dirDown, next_dirDown, blockMatch, next_blockMatch;
  logic ocOut, next_ocOut, cmpFlag, next_cmpFlag, ovfFlag, next_ovfFlag;
  logic outEn, next_outEn;
  atc_wave_e mode;
  atc_out_e outMode;
  logic isPwm, match, flagWr;

  assign mode = atc_wave_e'({ctrlReg[`ATC_CTRL_WAVE_HI], ctrlReg[`ATC_CTRL_WAVE_LO]});
  assign outMode = atc_out_e'(ctrlReg[`ATC_CTRL_OUT_HI:`ATC_CTRL_OUT_LO]);
  assign isPwm = (mode == ATC_WAVE_PHASE) || (mode == ATC_WAVE_FAST);
  // Continuous compare, blanked on the tick after a counter write.
  // Non-PWM modes compare against the written value at once.
  assign match = tick && !blockMatch && (cnt == (isPwm ? ocrAct : ocrReg));
  assign flagWr = regWr && (regAddr == `ATC_OFF_FLAGS);

  always_comb begin
    next_cnt = cnt;
    next_ocrAct = ocrAct;
    next_dirDown = dirDown;
    next_blockMatch = blockMatch;
    next_ocOut = ocOut;
    next_cmpFlag = cmpFlag;
    next_ovfFlag = ovfFlag;
    next_outEn = (outMode != ATC_OUT_OFF) && portDirBit;
    if (!isPwm) next_ocrAct = ocrReg;
    if (tick) next_blockMatch = 1'b0;
    if (tick) begin
      unique case (mode)
        ATC_WAVE_NORMAL, ATC_WAVE_CLEAR: begin
          if (mode == ATC_WAVE_CLEAR && match) begin
            next_cnt = `ATC_BOTTOM;
          end else begin
            next_cnt = cnt + 8'h01;
          end
          if (cnt == `ATC_TOP_MAX) next_ovfFlag = 1'b1;
          if (match) begin
            unique case (outMode)
              ATC_OUT_OFF: next_ocOut = ocOut;
              ATC_OUT_TOGGLE: next_ocOut = ~ocOut;
              ATC_OUT_CLEAR: next_ocOut = 1'b0;
              ATC_OUT_SET: next_ocOut = 1'b1;
            endcase
          end
        end
        ATC_WAVE_FAST: begin
          next_cnt = cnt + 8'h01;
          if (outMode[1] && match && ocrAct != `ATC_TOP_MAX) begin
            next_ocOut = outMode[0];
          end
          if (cnt == `ATC_TOP_MAX) begin
            next_ovfFlag = 1'b1;
            next_ocrAct = ocrReg;
            if (outMode[1]) next_ocOut = ~outMode[0];
          end
        end
        ATC_WAVE_PHASE: begin
          if (outMode[1] && match && ocrAct != `ATC_TOP_MAX) begin
            next_ocOut = dirDown ? ~outMode[0] : outMode[0];
          end
          if (!dirDown) begin
            if (cnt == `ATC_TOP_MAX) begin
              next_dirDown = 1'b1;
              next_cnt = cnt - 8'h01;
              next_ocrAct = ocrReg;
              // A compare at TOP gives the down-count result at TOP.
              if (outMode[1] && ocrAct == `ATC_TOP_MAX) next_ocOut = ~outMode[0];
            end else begin
              next_cnt = cnt + 8'h01;
            end
          end else if (cnt == `ATC_BOTTOM) begin
            next_dirDown = 1'b0;
            next_cnt = cnt + 8'h01;
            next_ovfFlag = 1'b1;
          end else begin
            next_cnt = cnt - 8'h01;
          end
        end
      endcase
    end
    // Forced compare uses the output mode now in force and touches no flag or
    // counter; it has no effect in either PWM mode.
    if (focPend && !isPwm) begin
      unique case (outMode)
        ATC_OUT_OFF: next_ocOut = next_ocOut;
        ATC_OUT_TOGGLE: next_ocOut = ~ocOut;
        ATC_OUT_CLEAR: next_ocOut = 1'b0;
        ATC_OUT_SET: next_ocOut = 1'b1;
      endcase
    end
    if (cntLoad) begin
      next_cnt = cntLoadVal;
      next_blockMatch = 1'b1;
    end
    // Clears come first so a same-cycle set survives.
    if (cmpVectorTaken || (flagWr && regWrData[`ATC_FLAG_CMP])) next_cmpFlag = 1'b0;
    if (ovfVectorTaken || (flagWr && regWrData[`ATC_FLAG_OVF])) next_ovfFlag = 1'b0;
    if (match) next_cmpFlag = 1'b1;
    if (tick && (cnt == `ATC_TOP_MAX) && (mode != ATC_WAVE_PHASE)) next_ovfFlag = 1'b1;
    if (tick && (mode == ATC_WAVE_PHASE) && dirDown && (cnt == `ATC_BOTTOM)) next_ovfFlag = 1'b1;
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      cnt <= 8'h00;
      ocrAct <= 8'h00;
      dirDown <= 1'b0;
      blockMatch <= 1'b0;
      ocOut <= 1'b0;
      cmpFlag <= 1'b0;
      ovfFlag <= 1'b0;
      outEn <= 1'b0;
    end else if (clkEn) begin
      cnt <= next_cnt;
      ocrAct <= next_ocrAct;
      dirDown <= next_dirDown;
      blockMatch <= next_blockMatch;
      ocOut <= next_ocOut;
      cmpFlag <= next_cmpFlag;
      ovfFlag <= next_ovfFlag;
      outEn <= next_outEn;
    end
  end

  assign compareOutPin = ocOut;
  assign compareOutEn = outEn;
  assign compareFlag = cmpFlag;
  assign overflowFlag = ovfFlag;

  // Read port: data stands only in the cycle after the read strobe.
  atc_byte_t next_rdData;

  always_comb begin
    next_rdData = 8'h00;
    if (regRd) begin
      unique case (regAddr)
        `ATC_OFF_CTRL: next_rdData = {1'b0, ctlTemp};
        `ATC_OFF_COUNT: next_rdData = cnt;
        `ATC_OFF_COMPARE: next_rdData = ocrTemp;
        `ATC_OFF_STATUS: next_rdData = {4'h0, asyncSel, cntBusy, ocrBusy, ctlBusy};
        `ATC_OFF_FLAGS: next_rdData = {6'h00, ovfFlag, cmpFlag};
        `ATC_OFF_PRESCALE: next_rdData = {7'h00, psrPend && asyncSel};
        default: next_rdData = 8'h00;
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      regRdData <= 8'h00;
    end else if (clkEn) begin
      regRdData <= next_rdData;
    end
  end

endmodule : atc_timer

/* File: include/atc_defs.svh */
// Constants for the 8-bit timer with one compare channel: register offsets,
// field positions, reset values and the prescaler width.
// Assumes the includer uses the plain register port with 3-bit addresses.
`ifndef ATC_DEFS_SVH
`define ATC_DEFS_SVH

`define ATC_ADDR_W 3
`define ATC_OFF_CTRL 3'h0
`define ATC_OFF_COUNT 3'h1
`define ATC_OFF_COMPARE 3'h2
`define ATC_OFF_STATUS 3'h3
`define ATC_OFF_FLAGS 3'h4
`define ATC_OFF_PRESCALE 3'h5

`define ATC_CTRL_FORCE 7
`define ATC_CTRL_WAVE_LO 6
`define ATC_CTRL_OUT_HI 5
`define ATC_CTRL_OUT_LO 4
`define ATC_CTRL_WAVE_HI 3
`define ATC_CTRL_RESET 7'h00

`define ATC_STAT_ASYNC 3
`define ATC_STAT_CNT_BUSY 2
`define ATC_STAT_CMP_BUSY 1
`define ATC_STAT_CTL_BUSY 0

`define ATC_FLAG_CMP 0
`define ATC_FLAG_OVF 1
`define ATC_PRESCALE_RST 0

`define ATC_TOP_MAX 8'hff
`define ATC_BOTTOM 8'h00
`define ATC_PRE_W 10
`define ATC_COMMIT_EDGES 2'h2

`endif

/* File: include/atc_pkg.sv */
// Types shared by the timer design: waveform modes and compare output modes.
// Assumes atc_defs.svh supplies the numeric constants.
package atc_pkg;

  typedef enum logic [1:0] {
    ATC_WAVE_NORMAL = 2'h0,
    ATC_WAVE_PHASE = 2'h1,
    ATC_WAVE_CLEAR = 2'h2,
    ATC_WAVE_FAST = 2'h3
  } atc_wave_e;

  typedef enum logic [1:0] {
    ATC_OUT_OFF = 2'h0,
    ATC_OUT_TOGGLE = 2'h1,
    ATC_OUT_CLEAR = 2'h2,
    ATC_OUT_SET = 2'h3
  } atc_out_e;

  typedef logic [7:0] atc_byte_t;

endpackage : atc_pkg

/* File: verification/atc_timer_checker.sv */
// Assertions on the timer's register port, compare pin and flags.
// Assumes it is bound into atc_timer; control is shadowed from sync writes.
`timescale 1ns/100ps
`include "atc_defs.svh"
module atc_timer_checker (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic clkEn,
  input wire logic [`ATC_ADDR_W-1:0] regAddr,
  input wire atc_pkg::atc_byte_t regWrData,
  input wire logic regWr,
  input wire logic regRd,
  input wire atc_pkg::atc_byte_t regRdData,
  input wire logic timerOscIn,
  input wire logic portDirBit,
  input wire logic cmpVectorTaken,
  input wire logic ovfVectorTaken,
  input wire logic compareOutPin,
  input wire logic compareOutEn,
  input wire logic compareFlag,
  input wire logic overflowFlag
);
  import atc_pkg::*;
  atc_byte_t shadowCtl;
  atc_byte_t next_shadowCtl;
  logic asyncSel;
  logic next_asyncSel;
  logic ctlWr;
  // Async writes commit late, so the shadow is trusted in sync mode only.
  assign ctlWr = regWr && clkEn && regAddr == `ATC_OFF_CTRL;
  always_comb begin
    next_shadowCtl = ctlWr ? regWrData : shadowCtl;
    next_asyncSel = asyncSel;
    if (regWr && clkEn && regAddr == `ATC_OFF_STATUS) begin
      next_asyncSel = regWrData[`ATC_STAT_ASYNC];
    end
  end
  always_ff @(posedge ref_clk) begin
    shadowCtl <= rst_n ? next_shadowCtl : 8'h00;
    asyncSel <= rst_n ? next_asyncSel : 1'b0;
  end
  default clocking @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);
  // A forced strobe with the counter stopped before and after the write.
  sequence sForceWr;
    ctlWr && regWrData[`ATC_CTRL_FORCE] && regWrData[2:0] == 3'h0 &&
      shadowCtl[2:0] == 3'h0 && !asyncSel;
  endsequence
  a_force_pwm_inert: assert property (
    sForceWr ##0 regWrData[`ATC_CTRL_WAVE_LO] |=> $stable(compareOutPin) [*3])
    else $error("Forced strobe changed the pin in a PWM mode.");
  a_force_toggles: assert property (
    sForceWr ##0 regWrData[6:3] == 4'h2 |-> ##[1:3] $changed(compareOutPin))
    else $error("Forced toggle did not reach the pin.");
  a_force_no_flag: assert property (
    sForceWr |=> !$rose(compareFlag) [*4])
    else $error("Forced strobe set the compare flag.");
  a_force_reads_zero: assert property (
    clkEn && regRd && regAddr == `ATC_OFF_CTRL |=> !regRdData[`ATC_CTRL_FORCE])
    else $error("Force bit read back as one.");
  a_pin_enable_follow: assert property (
    clkEn && !asyncSel |=> compareOutEn == $past(shadowCtl[5:4] != 2'h0 && portDirBit))
    else $error("Pin enable does not follow mode and direction.");
  a_stopped_quiet: assert property (
    !asyncSel && shadowCtl[2:0] == 3'h0 && $past(shadowCtl[2:0]) == 3'h0
      |=> !$rose(compareFlag) && !$rose(overflowFlag))
    else $error("A flag rose with the clock stopped.");
  a_rd_idle_zero: assert property (
    clkEn && !regRd |=> regRdData == 8'h00)
    else $error("Read data present without a read.");
  a_unmapped_zero: assert property (
    clkEn && regRd && regAddr[2:1] == 2'h3 |=> regRdData == 8'h00)
    else $error("Unmapped address returned data.");
endmodule : atc_timer_checker

bind atc_timer atc_timer_checker u_checker (
  .ref_clk(ref_clk), .rst_n(rst_n), .clkEn(clkEn), .regAddr(regAddr),
  .regWrData(regWrData), .regWr(regWr), .regRd(regRd), .regRdData(regRdData),
  .timerOscIn(timerOscIn), .portDirBit(portDirBit), .cmpVectorTaken(cmpVectorTaken),
  .ovfVectorTaken(ovfVectorTaken), .compareOutPin(compareOutPin),
  .compareOutEn(compareOutEn), .compareFlag(compareFlag), .overflowFlag(overflowFlag)
);

/* File: verification/testbench.sv */
// Self-checking bench for the timer: register port, modes, clock taps,
// forced compare and asynchronous update.
// Assumes a 100 MHz ref_clk; the oscillator input is modelled here.
`timescale 1ns/100ps
`include "atc_defs.svh"
module testbench;
  import atc_pkg::*;
  logic ref_clk;
  logic rst_n;
  logic regWr;
  logic regRd;
  logic timerOscIn;
  logic portDirBit;
  logic cmpVectorTaken;
  logic ovfVectorTaken;
  logic oscRun;
  logic clkEn;
  logic [`ATC_ADDR_W-1:0] regAddr;
  atc_byte_t regWrData;
  atc_byte_t regRdData;
  atc_byte_t rd;
  logic compareOutPin;
  logic compareOutEn;
  logic compareFlag;
  logic overflowFlag;
  int errCount = 0;
  int nTests = 0;
  int cyc = 0;
  int hi;
  int div[8] = '{0, 1, 8, 32, 64, 128, 256, 1024};
  // Rows: address, write data, expected read back.
  logic [23:0] rows[7] = '{24'h013737, 24'h025a5a, 24'h061100, 24'h07ff00,
    24'h00f878, 24'h000000, 24'h030000};
  logic [2:0] fc[4] = '{3'h7, 3'h2, 3'h3, 3'h4};
  atc_byte_t pc[5] = '{8'h69, 8'h79, 8'h61, 8'h71, 8'h69};
  atc_byte_t pv[5] = '{8'h40, 8'h40, 8'h40, 8'h40, 8'hff};
  int pe[5] = '{259, 761, 256, 764, 1020};

  atc_timer dut (
    .ref_clk(ref_clk), .rst_n(rst_n), .clkEn(clkEn), .regAddr(regAddr),
    .regWrData(regWrData), .regWr(regWr), .regRd(regRd), .regRdData(regRdData),
    .timerOscIn(timerOscIn), .portDirBit(portDirBit), .cmpVectorTaken(cmpVectorTaken),
    .ovfVectorTaken(ovfVectorTaken), .compareOutPin(compareOutPin),
    .compareOutEn(compareOutEn), .compareFlag(compareFlag), .overflowFlag(overflowFlag)
  );

  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  // The oscillator runs far below a quarter of ref_clk, as the block needs.
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (oscRun && cyc % 12 == 0) timerOscIn <= ~timerOscIn;
    if (cyc == 40000) begin
      errCount++;
      tally_and_finish();
    end
  end

  task automatic chk(input string nm, input atc_byte_t exp, input atc_byte_t got);
    nTests++;
    if (got !== exp) begin
      errCount++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task automatic chk_range(input string nm, input int lo, input int hh,
                           input logic [10:0] got);
    nTests++;
    if ($isunknown(got) || got < lo || got > hh) begin
      errCount++;
      $display("[FAIL] %s expected %0d..%0d seen %0d", nm, lo, hh, got);
    end
  endtask : chk_range

  task automatic tk(input int n);
    repeat (n) @(posedge ref_clk);
  endtask : tk

  // An idle cycle follows each write so the strobe is never driven twice at one edge.
  task automatic wr(input logic [2:0] a, input atc_byte_t d);
    regAddr <= a;
    regWrData <= d;
    regWr <= 1'b1;
    @(posedge ref_clk);
    regWr <= 1'b0;
    @(posedge ref_clk);
  endtask : wr

  task automatic rdr(input logic [2:0] a, output atc_byte_t d);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge ref_clk);
    regRd <= 1'b0;
    @(posedge ref_clk);
    d = regRdData;
  endtask : rdr

  task automatic do_reset;
    rst_n <= 1'b0;
    tk(16);
    rst_n <= 1'b1;
    tk(1);
  endtask : do_reset

  task automatic tally_and_finish;
    if (errCount == 0 && nTests > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : tally_and_finish

  initial begin
    rst_n = 1'b0;
    regWr = 1'b0;
    regRd = 1'b0;
    regAddr = '0;
    regWrData = 8'h00;
    timerOscIn = 1'b0;
    portDirBit = 1'b1;
    cmpVectorTaken = 1'b0;
    ovfVectorTaken = 1'b0;
    oscRun = 1'b0;
    clkEn = 1'b1;
    do_reset();
    for (int a = 0; a < 4; a++) begin
      rdr(3'(a), rd);
      chk("reset value", 8'h00, rd);
    end
    foreach (rows[i]) begin
      wr(rows[i][18:16], rows[i][15:8]);
      tk(1);
      rdr(rows[i][18:16], rd);
      chk("readback", rows[i][7:0], rd);
    end
    for (int k = 1; k < 8; k++) begin
      wr(`ATC_OFF_COUNT, 8'h00);
      wr(`ATC_OFF_PRESCALE, 8'h01);
      wr(`ATC_OFF_CTRL, {5'h00, 3'(k)});
      tk(div[k] * 5 - 2);
      wr(`ATC_OFF_CTRL, 8'h00);
      rdr(`ATC_OFF_COUNT, rd);
      chk_range("clock tap", 4, 6, {3'h0, rd});
    end
    foreach (fc[i]) begin
      wr(`ATC_OFF_CTRL, {2'b10, fc[i][2:1], 4'h0});
      tk(3);
      chk("forced pin", {7'h00, fc[i][0]}, {7'h00, compareOutPin});
    end
    chk("pin enable", 8'h01, {7'h00, compareOutEn});
    portDirBit <= 1'b0;
    tk(2);
    chk("pin enable", 8'h00, {7'h00, compareOutEn});
    portDirBit <= 1'b1;
    chk("forced flag", 8'h00, {7'h00, compareFlag});
    for (int i = 0; i < 2; i++) begin
      wr(`ATC_OFF_CTRL, i ? 8'hf0 : 8'hf8);
      tk(3);
      chk("pwm force", 8'h00, {7'h00, compareOutPin});
    end
    wr(`ATC_OFF_CTRL, 8'h00);
    wr(`ATC_OFF_COMPARE, 8'h03);
    wr(`ATC_OFF_COUNT, 8'h00);
    wr(`ATC_OFF_CTRL, 8'h11);
    tk(300);
    wr(`ATC_OFF_CTRL, 8'h00);
    chk("match flags", 8'h03, {6'h00, overflowFlag, compareFlag});
    cmpVectorTaken <= 1'b1;
    tk(1);
    cmpVectorTaken <= 1'b0;
    ovfVectorTaken <= 1'b1;
    tk(1);
    ovfVectorTaken <= 1'b0;
    tk(1);
    chk("flag clear", 8'h00, {6'h00, overflowFlag, compareFlag});
    wr(`ATC_OFF_COMPARE, 8'h05);
    wr(`ATC_OFF_COUNT, 8'h00);
    wr(`ATC_OFF_CTRL, 8'h09);
    tk(100);
    wr(`ATC_OFF_CTRL, 8'h00);
    rdr(`ATC_OFF_COUNT, rd);
    chk_range("clear on match", 0, 5, {3'h0, rd});
    chk("ctc flags", 8'h01, {6'h00, overflowFlag, compareFlag});
    wr(`ATC_OFF_FLAGS, 8'h01);
    chk("flag write", 8'h00, {7'h00, compareFlag});
    // Two ticks run with the enable high; the twenty frozen cycles add none.
    wr(`ATC_OFF_COUNT, 8'h00);
    wr(`ATC_OFF_CTRL, 8'h01);
    clkEn <= 1'b0;
    tk(20);
    clkEn <= 1'b1;
    wr(`ATC_OFF_CTRL, 8'h00);
    rdr(`ATC_OFF_COUNT, rd);
    chk("clock enable", 8'h02, rd);
    foreach (pc[i]) begin
      wr(`ATC_OFF_CTRL, 8'h00);
      wr(`ATC_OFF_COMPARE, pv[i]);
      wr(`ATC_OFF_COUNT, 8'h00);
      wr(`ATC_OFF_CTRL, pc[i]);
      tk(300);
      hi = 0;
      repeat (1020) begin
        @(posedge ref_clk);
        hi += compareOutPin;
      end
      chk_range("duty", pe[i] - 16, pe[i] + 16, 11'(hi));
    end
    oscRun <= 1'b1;
    wr(`ATC_OFF_STATUS, 8'h08);
    wr(`ATC_OFF_COMPARE, 8'h22);
    wr(`ATC_OFF_COUNT, 8'h10);
    wr(`ATC_OFF_CTRL, 8'h00);
    rdr(`ATC_OFF_STATUS, rd);
    chk("busy set", 8'h0f, rd);
    rdr(`ATC_OFF_COMPARE, rd);
    chk("temp read", 8'h22, rd);
    tk(100);
    rdr(`ATC_OFF_STATUS, rd);
    chk("busy clear", 8'h08, rd);
    rdr(`ATC_OFF_COUNT, rd);
    chk_range("async count", 16, 18, {3'h0, rd});
    do_reset();
    rdr(`ATC_OFF_STATUS, rd);
    chk("reset status", 8'h00, rd);
    chk("reset pins", 8'h00, {4'h0, compareOutPin, compareOutEn, compareFlag, overflowFlag});
    tally_and_finish();
  end
endmodule : testbench
